// ---- core/tmr1_pkg.sv ----
// tmr1_pkg: constants, field layouts and carrier types of the timer 1 control block.
// assumes a single 100 MHz ref_clk and an Avalon-MM master with byte addressing.
package tmr1_pkg;
	// register byte offsets, one aligned 32-bit word each
	localparam logic [4:0] OFF_CTRL = 5'h00; // timer1_control
	localparam logic [4:0] OFF_CMP = 5'h04; // compare_value_register
	localparam logic [4:0] OFF_CAP = 5'h08; // capture_pulse_register
	localparam logic [4:0] OFF_STATUS = 5'h0c; // sticky events, write one to clear
	localparam logic [4:0] OFF_MASK = 5'h10; // interrupt mask
	localparam logic [4:0] OFF_COUNT = 5'h14; // live up-counter value
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned TREG_W = 16;

	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] TREG_RESET = 16'hffff;

	// start_control encodings
	localparam logic [1:0] START_STOP = 2'h0; // stop and clear counter
	localparam logic [1:0] START_CMD = 2'h1; // command start
	localparam logic [1:0] START_RISE = 2'h2; // start on count pin rising edge
	localparam logic [1:0] START_FALL = 2'h3; // start on count pin falling edge

	// source_clock_select encodings
	localparam logic [1:0] CLK_SLOW = 2'h0; // fc/2^11 or fs/2^3
	localparam logic [1:0] CLK_MID = 2'h1; // fc/2^7
	localparam logic [1:0] CLK_FAST = 2'h2; // fc/2^3
	localparam logic [1:0] CLK_PIN = 2'h3; // count input pin

	// operating_mode_select encodings
	localparam logic [1:0] MODE_TIMER = 2'h0; // timer, trigger timer, event counter
	localparam logic [1:0] MODE_WINDOW = 2'h1;
	localparam logic [1:0] MODE_PWM_MEAS = 2'h2; // pulse width measurement
	localparam logic [1:0] MODE_PPG = 2'h3; // programmable_pulse_output

	// divider taps, as powers of two of fc or fs
	localparam int unsigned PRE_W = 11;
	localparam int unsigned TAP_SLOW = 11;
	localparam int unsigned TAP_MID = 7;
	localparam int unsigned TAP_FAST = 3;
	localparam int unsigned FS_DIV_W = 3;

	// status and mask bit positions
	localparam int unsigned EV_MATCH = 0; // counter matched compare value
	localparam int unsigned EV_CAPTURE = 1; // auto-capture took a value
	localparam int unsigned EV_STOP = 2; // stop mode forced the timer off
	localparam int unsigned EV_W = 3;

	// timer1_control layout, bit 7 down to bit 0
	typedef struct packed {
		logic ff_ctrl; // output_flipflop_control
		logic acap; // auto_capture_enable, or pulse output control in ppg mode
		logic [1:0] start; // start_control
		logic [1:0] clk_sel; // source_clock_select
		logic [1:0] mode; // operating_mode_select
	} tmr1_ctrl_t;

	// avalon-mm request from the master
	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [3:0] byteenable;
	} tmr1_avs_req_t;

	// counter run state
	typedef enum logic [1:0] {
		ST_STOPPED = 2'b00,
		ST_ARMED = 2'b01,
		ST_COUNTING = 2'b10
	} tmr1_run_t;
endpackage

// ---- core/tmr1_stage_reg.sv ----
// tmr1_stage_reg: one double staged 16-bit timer register.
// assumes byte writes and the commit tick come from logic on the same clock.
`timescale 1ns/1ns
module tmr1_stage_reg
	import tmr1_pkg::*;
#(
	parameter int unsigned W = TREG_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [W-1:0] wdata,
	input wire logic commit,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic [W-1:0] active
);
	logic [W/2-1:0] lo_r, lo_nxt; // staged lower byte
	logic [W/2-1:0] hi_r, hi_nxt; // staged upper byte
	logic pend_r, pend_nxt; // upper byte written, not yet active
	logic [W-1:0] act_r, act_nxt; // value the counter logic sees

	// staging and transfer on the source clock tick
	always_comb begin
		lo_nxt = lo_r;
		hi_nxt = hi_r;
		pend_nxt = pend_r;
		act_nxt = act_r;
		if (load) begin // capture writes straight through
			act_nxt = load_val;
		end else if (pend_r && commit) begin
			act_nxt = {hi_r, lo_r};
			pend_nxt = 1'b0;
		end
		if (wr_lo) begin // lower byte alone never reaches the active value
			lo_nxt = wdata[W/2-1:0];
		end
		if (wr_hi) begin // a fresh upper write re-arms, so it wins over a commit
			hi_nxt = wdata[W-1:W/2];
			pend_nxt = 1'b1;
		end
	end

	// registers only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lo_r <= TREG_RESET[W/2-1:0];
			hi_r <= TREG_RESET[W-1:W/2];
			pend_r <= 1'b0;
			act_r <= TREG_RESET[W-1:0];
		end else begin
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
			pend_r <= pend_nxt;
			act_r <= act_nxt;
		end
	end

	assign active = act_r;
endmodule

// ---- core/tmr1_ctrl.sv ----
// tmr1_ctrl: control register, clock selection, staged timer registers and auto-capture
// of the 16-bit timer 1, reached over avalon-mm.
// assumes pins and the low-frequency clock arrive unsynchronised; divider select is local.
// How it works
// - one control byte, compare and capture registers
// - clock select picks fc or fs taps, pin
// - timer registers take effect after upper byte
// - auto-capture only in timer, event, window modes
// - stop mode clears start field, halts counter
// - capture copies counter on every source tick while counting
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ns
module tmr1_ctrl
	import tmr1_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire tmr1_avs_req_t avs_req,
	output logic [DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic fs_clk_pin,
	input wire logic count_input_pin,
	input wire logic divider_select_bit,
	input wire logic slow_mode_pin,
	input wire logic stop_mode_pin,
	output logic irq
);
	// true when the low n bits of the prescaler are all ones
	function automatic logic tap_hit(input logic [PRE_W-1:0] v, input int unsigned n);
		logic [PRE_W-1:0] m;
		m = PRE_W'((32'h1 << n) - 32'h1);
		tap_hit = ((v & m) == m);
	endfunction

	// synchronisers: stage 1 feeds only stage 2
	logic [2:0] fs_s1_r, fs_s2_r; // fs clock, count pin, slow mode
	logic stop_s1_r, stop_s2_r; // stop mode request
	logic fs_d_r, pin_d_r, stop_d_r; // delayed copies for edges
	logic slow_lvl;
	logic fs_rise, pin_rise, pin_fall, stop_entry;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fs_s1_r <= 3'h0;
			fs_s2_r <= 3'h0;
			stop_s1_r <= 1'b0;
			stop_s2_r <= 1'b0;
			fs_d_r <= 1'b0;
			pin_d_r <= 1'b0;
			stop_d_r <= 1'b0;
		end else begin
			fs_s1_r <= {slow_mode_pin, count_input_pin, fs_clk_pin};
			fs_s2_r <= fs_s1_r;
			stop_s1_r <= stop_mode_pin;
			stop_s2_r <= stop_s1_r;
			fs_d_r <= fs_s2_r[0];
			pin_d_r <= fs_s2_r[1];
			stop_d_r <= stop_s2_r;
		end
	end

	always_comb begin
		fs_rise = fs_s2_r[0] & ~fs_d_r;
		pin_rise = fs_s2_r[1] & ~pin_d_r;
		pin_fall = ~fs_s2_r[1] & pin_d_r;
		slow_lvl = fs_s2_r[2];
		stop_entry = stop_s2_r & ~stop_d_r; // entry edge only; level re-forces nothing
	end

	// dividers: fc prescaler and fs/8
	logic [PRE_W-1:0] pre_r, pre_nxt;
	logic [FS_DIV_W-1:0] fsd_r, fsd_nxt;
	logic fs_tick;
	always_comb begin
		pre_nxt = pre_r + PRE_W'(1);
		fsd_nxt = fs_rise ? fsd_r + FS_DIV_W'(1) : fsd_r;
		fs_tick = fs_rise && (fsd_r == {FS_DIV_W{1'b1}});
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pre_r <= '0;
			fsd_r <= '0;
		end else begin
			pre_r <= pre_nxt;
			fsd_r <= fsd_nxt;
		end
	end

	// control, status, mask and bus answer
	tmr1_ctrl_t ctrl_r, ctrl_nxt, wctrl;
	logic [EV_W-1:0] st_r, st_nxt, mask_r, mask_nxt, ev;
	logic wait_r, wait_nxt;
	logic [DATA_W-1:0] rd_r, rd_nxt;
	logic irq_r, irq_nxt;
	logic acc, wr_acc;
	logic [TREG_W-1:0] cmp_val, cap_val, cnt_r, cnt_nxt;
	tmr1_run_t run_r, run_nxt;
	logic src_tick, cap_on, cap_load, cmp_match;

	// one wait cycle, then a single-cycle answer
	always_comb begin
		acc = (avs_req.read | avs_req.write) & ~wait_r;
		wr_acc = acc & avs_req.write;
		wait_nxt = ~((avs_req.read | avs_req.write) & wait_r);
	end

	// source clock selection
	always_comb begin
		unique case (ctrl_r.clk_sel)
			CLK_SLOW: begin // low-frequency path in slow mode or with divider select
				src_tick = (divider_select_bit | slow_lvl) ? fs_tick
					: tap_hit(pre_r, TAP_SLOW);
			end
			CLK_MID: src_tick = tap_hit(pre_r, TAP_MID);
			CLK_FAST: src_tick = tap_hit(pre_r, TAP_FAST);
			CLK_PIN: src_tick = pin_rise;
		endcase
	end

	// control register writes, with fields locked while running
	always_comb begin
		wctrl = avs_req.writedata[7:0];
		ctrl_nxt = ctrl_r;
		if (wr_acc && avs_req.address == OFF_CTRL && avs_req.byteenable[0]) begin
			ctrl_nxt.start = wctrl.start;
			ctrl_nxt.acap = wctrl.acap;
			if (ctrl_r.start == START_STOP) begin // the whole byte only takes while stopped
				ctrl_nxt = wctrl;
			end else if (ctrl_r.mode == MODE_PPG) begin
				ctrl_nxt.acap = ctrl_r.acap; // pulse output control is locked too
			end
		end
		if (stop_entry) begin // hardware clear beats a simultaneous write
			ctrl_nxt.start = START_STOP;
		end
		mask_nxt = mask_r;
		if (wr_acc && avs_req.address == OFF_MASK && avs_req.byteenable[0]) begin
			mask_nxt = avs_req.writedata[EV_W-1:0];
		end
		st_nxt = st_r;
		if (wr_acc && avs_req.address == OFF_STATUS && avs_req.byteenable[0]) begin
			st_nxt = st_r & ~avs_req.writedata[EV_W-1:0];
		end
		st_nxt = st_nxt | ev; // a new event wins over the clear
		irq_nxt = |(st_nxt & mask_nxt);
	end

	// counter run state and up-count
	always_comb begin
		run_nxt = run_r;
		cnt_nxt = cnt_r;
		cmp_match = 1'b0;
		unique case (ctrl_r.start)
			START_STOP: begin // stop and clear
				run_nxt = ST_STOPPED;
				cnt_nxt = '0;
			end
			START_CMD: run_nxt = ST_COUNTING;
			START_RISE: if (run_r == ST_STOPPED) run_nxt = pin_rise ? ST_COUNTING : ST_ARMED;
				else if (run_r == ST_ARMED && pin_rise) run_nxt = ST_COUNTING;
			START_FALL: if (run_r == ST_STOPPED) run_nxt = pin_fall ? ST_COUNTING : ST_ARMED;
				else if (run_r == ST_ARMED && pin_fall) run_nxt = ST_COUNTING;
		endcase
		if (stop_entry) begin // halt at once on stop mode entry
			run_nxt = ST_STOPPED;
			cnt_nxt = '0;
		end else if (run_r == ST_COUNTING && ctrl_r.start != START_STOP && src_tick) begin
			if (cnt_r == cmp_val) begin // match clears and restarts
				cnt_nxt = '0;
				cmp_match = 1'b1;
			end else begin
				cnt_nxt = cnt_r + TREG_W'(1);
			end
		end
	end

	// capture only in the modes that allow it
	always_comb begin
		cap_on = ctrl_r.acap && (ctrl_r.mode == MODE_TIMER || ctrl_r.mode == MODE_WINDOW);
		cap_load = cap_on && run_r == ST_COUNTING && src_tick;
		ev = '0;
		ev[EV_MATCH] = cmp_match;
		ev[EV_CAPTURE] = cap_load;
		ev[EV_STOP] = stop_entry;
	end

	// read data mux; unmapped words read zero
	// latched on the edge that ends the wait cycle, so the data stand in the cycle waitrequest is low
	always_comb begin
		rd_nxt = '0;
		if (avs_req.read && wait_r) begin
			unique case (avs_req.address)
				OFF_CTRL: rd_nxt = DATA_W'(ctrl_r);
				OFF_CMP: rd_nxt = DATA_W'(cmp_val);
				OFF_CAP: rd_nxt = DATA_W'(cap_val);
				OFF_STATUS: rd_nxt = DATA_W'(st_r);
				OFF_MASK: rd_nxt = DATA_W'(mask_r);
				OFF_COUNT: rd_nxt = DATA_W'(cnt_r);
				default: rd_nxt = '0;
			endcase
		end
	end

	// registers only
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= CTRL_RESET;
			st_r <= '0;
			mask_r <= '0;
			wait_r <= 1'b1;
			rd_r <= '0;
			irq_r <= 1'b0;
			run_r <= ST_STOPPED;
			cnt_r <= '0;
		end else begin
			ctrl_r <= ctrl_nxt;
			st_r <= st_nxt;
			mask_r <= mask_nxt;
			wait_r <= wait_nxt;
			rd_r <= rd_nxt;
			irq_r <= irq_nxt;
			run_r <= run_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// two staged timer registers; the second takes writes only in ppg mode
	logic [1:0] sel_wr, sel_lo, sel_hi;
	logic [1:0][TREG_W-1:0] treg_val;
	always_comb begin
		sel_wr[0] = wr_acc && avs_req.address == OFF_CMP;
		sel_wr[1] = wr_acc && avs_req.address == OFF_CAP && ctrl_r.mode == MODE_PPG;
		sel_lo = sel_wr & {2{avs_req.byteenable[0]}};
		sel_hi = sel_wr & {2{avs_req.byteenable[1]}};
	end
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_treg
			tmr1_stage_reg #(.W(TREG_W)) u_treg (
				.clk(ref_clk),
				.rst(rst),
				.wr_lo(sel_lo[gi]),
				.wr_hi(sel_hi[gi]),
				.wdata(avs_req.writedata[TREG_W-1:0]),
				.commit(src_tick),
				.load(gi == 1 ? cap_load : 1'b0),
				.load_val(cnt_r),
				.active(treg_val[gi])
			);
		end
	endgenerate
	assign cmp_val = treg_val[0];
	assign cap_val = treg_val[1];

	assign avs_readdata = rd_r;
	assign avs_waitrequest = wait_r;
	assign irq = irq_r;
endmodule

// ---- tb/tmr1_ctrl_chk.sv ----
// tmr1_ctrl_chk: bus, readback width and stop-entry interrupt checks on tmr1_ctrl ports.
// assumes one clock, async active-high reset, bound to every tmr1_ctrl instance.
`timescale 1ns/1ns
module tmr1_ctrl_chk
	import tmr1_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire tmr1_avs_req_t avs_req,
	input wire logic [DATA_W-1:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic fs_clk_pin,
	input wire logic count_input_pin,
	input wire logic divider_select_bit,
	input wire logic slow_mode_pin,
	input wire logic stop_mode_pin,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic mask_stop_r; // shadow of mask bit for stop entry
	logic mask_stop_nxt;
	wire logic req = avs_req.read | avs_req.write; // any pending access
	wire logic rd_ack = avs_req.read & ~avs_waitrequest; // read answered
	// follow mask writes so the stop assertion knows if irq must rise
	always_comb begin
		mask_stop_nxt = mask_stop_r;
		if (avs_req.write && !avs_waitrequest && avs_req.address == OFF_MASK
			&& avs_req.byteenable[0]) begin
			mask_stop_nxt = avs_req.writedata[EV_STOP];
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mask_stop_r <= 1'b0;
		end else begin
			mask_stop_r <= mask_stop_nxt;
		end
	end
	a_req_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_wait_idle: assert property (!req && avs_waitrequest |=> avs_waitrequest)
		else $error("answer without a request");
	a_data_rest: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
		else $error("read data outside the answer cycle");
	a_unmapped_zero: assert property (rd_ack && avs_req.address > OFF_COUNT |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_width: assert property (rd_ack && avs_req.address == OFF_CTRL |-> avs_readdata[31:8] == 24'h0)
		else $error("control readback wider than a byte");
	a_treg_width: assert property (rd_ack && (avs_req.address == OFF_CMP || avs_req.address == OFF_CAP)
		|-> avs_readdata[31:16] == 16'h0)
		else $error("timer register readback wider than 16 bits");
	a_stop_irq: assert property ($rose(stop_mode_pin) && mask_stop_r |-> ##[1:8] irq)
		else $error("stop entry did not raise the interrupt");
	c_read: cover property (rd_ack);
	c_write: cover property (avs_req.write && !avs_waitrequest);
	c_stop: cover property ($rose(stop_mode_pin) && mask_stop_r);
endmodule
bind tmr1_ctrl tmr1_ctrl_chk tmr1_ctrl_chk_i (.ref_clk(ref_clk), .rst(rst), .avs_req(avs_req),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fs_clk_pin(fs_clk_pin),
	.count_input_pin(count_input_pin), .divider_select_bit(divider_select_bit),
	.slow_mode_pin(slow_mode_pin), .stop_mode_pin(stop_mode_pin), .irq(irq));

// ---- tb/tmr1_ctrl_test.sv ----
// tmr1_ctrl_test: self-checking bench for tmr1_ctrl, reads checked from an expectation queue.
// assumes the count pin is the source clock so staging and capture ticks are under bench control.
`timescale 1ns/1ns
module tmr1_ctrl_test
	import tmr1_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	tmr1_avs_req_t avs_req = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic fs_clk_pin = 1'b0; // fs source, pulsed by tick
	logic count_input_pin = 1'b0; // source ticks come from here
	logic divider_select_bit = 1'b0;
	logic slow_mode_pin = 1'b0;
	logic stop_mode_pin = 1'b0;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] expq[$]; // expected read data, oldest first
	logic [7:0] r;
	tmr1_ctrl tmr1_ctrl_i (.ref_clk(ref_clk), .rst(rst), .avs_req(avs_req),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fs_clk_pin(fs_clk_pin),
		.count_input_pin(count_input_pin), .divider_select_bit(divider_select_bit),
		.slow_mode_pin(slow_mode_pin), .stop_mode_pin(stop_mode_pin), .irq(irq));
	always #5 ref_clk = ~ref_clk;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// one avalon access: hold until waitrequest is sampled low, then release
	task acc(input logic rd, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		avs_req <= '{rd, !rd, a, d, be};
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 100) fail_count++;
		avs_req <= '0;
		@(posedge ref_clk); // idle edge keeps one assignment per step
	endtask
	task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
		acc(1'b0, a, d, be);
	endtask
	task rd(input logic [4:0] a, input logic [31:0] exp);
		expq.push_back(exp);
		acc(1'b1, a, 32'h0, 4'hf);
	endtask
	// k pin pulses on the count pin or fs, wide enough for the 2ff synchroniser
	task tick(input int k, input logic on_fs = 1'b0);
		repeat (k) begin
			if (on_fs) fs_clk_pin <= 1'b1;
			else count_input_pin <= 1'b1;
			repeat (4) @(posedge ref_clk);
			fs_clk_pin <= 1'b0;
			count_input_pin <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		repeat (4) @(posedge ref_clk);
	endtask
	// read monitor and hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
		if (avs_req.read && avs_waitrequest === 1'b0) chk(avs_readdata, expq.pop_front());
	end
	initial begin
		void'($urandom(32'hec08e9ca));
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(OFF_CTRL, 32'h0);
		rd(OFF_CMP, 32'hffff);
		rd(OFF_CAP, 32'hffff);
		wr(5'h18, 32'h5a);
		rd(5'h18, 32'h0);
		// every clock and mode code while stopped, flip-flop bit kept low
		for (int i = 0; i < 16; i++) begin
			r = {1'b0, 1'($urandom()), 2'h0, i[3:0]};
			wr(OFF_CTRL, {24'h0, r});
			rd(OFF_CTRL, {24'h0, r});
		end
		// slow source from fs/8, chosen by divider select, then by slow mode
		divider_select_bit <= 1'b1;
		wr(OFF_CTRL, 32'h10);
		tick(16, 1'b1);
		rd(OFF_COUNT, 32'h2);
		slow_mode_pin <= 1'b1;
		repeat (4) @(posedge ref_clk);
		divider_select_bit <= 1'b0;
		tick(8, 1'b1);
		rd(OFF_COUNT, 32'h3);
		wr(OFF_CTRL, 32'h0);
		slow_mode_pin <= 1'b0;
		wr(OFF_CTRL, 32'h0c);
		wr(OFF_CMP, 32'h34, 4'h1);
		tick(1);
		rd(OFF_CMP, 32'hffff);
		wr(OFF_CMP, 32'h1200, 4'h2);
		rd(OFF_CMP, 32'hffff);
		tick(1);
		rd(OFF_CMP, 32'h1234);
		wr(OFF_CAP, 32'h5555, 4'h3);
		tick(1);
		rd(OFF_CAP, 32'hffff);
		wr(OFF_CTRL, 32'h5c);
		wr(OFF_CTRL, 32'h5d);
		rd(OFF_CTRL, 32'h5c);
		tick(5);
		rd(OFF_COUNT, 32'h5);
		rd(OFF_CAP, 32'h4);
		rd(OFF_STATUS, 32'h2);
		wr(OFF_MASK, 32'h2);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b1);
		wr(OFF_STATUS, 32'h2);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b0);
		wr(OFF_CTRL, 32'h0c);
		rd(OFF_COUNT, 32'h0);
		// edge starts: the trigger edge moves armed to counting but is not counted, later rises count
		wr(OFF_CTRL, 32'h2c);
		tick(3);
		rd(OFF_COUNT, 32'h2);
		wr(OFF_CTRL, 32'h0c);
		wr(OFF_CTRL, 32'h3c);
		tick(3);
		rd(OFF_COUNT, 32'h2);
		wr(OFF_CTRL, 32'h0c);
		wr(OFF_CTRL, 32'h4e);
		wr(OFF_CTRL, 32'h5e);
		tick(3);
		rd(OFF_CAP, 32'h4);
		wr(OFF_CTRL, 32'h0c);
		wr(OFF_CTRL, 32'h0f);
		wr(OFF_CAP, 32'h0222, 4'h3);
		tick(1);
		rd(OFF_CAP, 32'h0222);
		wr(OFF_CTRL, 32'h8f);
		rd(OFF_CTRL, 32'h8f);
		wr(OFF_CTRL, 32'h1c);
		wr(OFF_MASK, 32'h4);
		stop_mode_pin <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk(irq, 1'b1);
		rd(OFF_CTRL, 32'h0c);
		stop_mode_pin <= 1'b0;
		wr(OFF_CTRL, 32'h1c);
		rd(OFF_CTRL, 32'h1c);
		results();
	end
endmodule
